// ---- rtl/central_timing_unit_map.vh ----
`ifndef CENTRAL_TIMING_UNIT_MAP_VH
`define CENTRAL_TIMING_UNIT_MAP_VH

// System clock and reference rates.
`define SYS_CLK_HZ 125000000
`define REF_HZ 1024000
`define EXT_REF_HZ 1000

// Crystal mode ratio REF_HZ / SYS_CLK_HZ reduced to 128 / 15625.
`define XTAL_STEP 18'h00080
`define XTAL_MOD 18'h03D09

// Integrated mode: 1024 reference ticks per external reference period.
`define EXT_STEP 18'h00400
// Nominal external period in system cycles (SYS_CLK_HZ / EXT_REF_HZ).
`define EXT_PERIOD_NOM 18'h1E848
// Shortest external period accepted as genuine; shorter edges are glitches.
`define EXT_PERIOD_MIN 18'h00400
`define PERIOD_MAX 18'h3FFFF

// Divider counts on the 1024 kHz reference.
`define DIV_512K_HALF 8'h01
`define DIV_6K4 8'hA0
`define DIV_6K4_HALF 8'h50
`define DIV_50MS 16'hC800
`define RTI_PER_HALF_SEC 4'hA
`define RTI_PER_SEC 5'h14

// Time chain limits.
`define HALF_WRAP 1'h1
`define SEC_WRAP 6'h3B
`define MIN_WRAP 6'h3B
`define HOUR_WRAP 5'h17
`define DAY_FIRST 5'h01
`define DAY_LAST 5'h1F

// Binary time word field positions.
`define BIN_HALF_POS 0
`define BIN_SEC_POS 1
`define BIN_MIN_POS 7
`define BIN_HOUR_POS 13
`define BIN_DAY_POS 18
`define BIN_WIDTH 23
`define BCD_WIDTH 33

`endif

// ---- rtl/central_timing_unit.v ----
`timescale 1ns/1ns
`include "central_timing_unit_map.vh"

module central_timing_unit (
    // Clock and reset.
    input wire I_REF_CLK,
    input wire I_RST_N,
    // Reference selection and external reference.
    input wire I_INTEGRATED,
    input wire I_EXT_1KHZ,
    // Failure simulation gates, high suppresses the output.
    input wire I_FAIL_512K,
    input wire I_FAIL_6K4,
    input wire I_FAIL_PPS,
    input wire I_FAIL_RTI,
    // Preset switches and load strobe.
    input wire I_PRESET_LOAD,
    input wire [4:0] I_PRESET_DAY,
    input wire [4:0] I_PRESET_HOUR,
    input wire [5:0] I_PRESET_MIN,
    // Timing outputs.
    output reg O_CLK_512K,
    output reg O_CLK_6K4,
    output reg O_PPS,
    output reg O_RTI,
    // Time words and status.
    output reg [`BIN_WIDTH-1:0] O_TIME_BIN,
    output reg [`BCD_WIDTH-1:0] O_TIME_BCD,
    output reg O_RUNNING
);

    // Binary to two BCD digits for values up to 63; the tens digit never exceeds 6.
    function [7:0] to_bcd;
        input [5:0] v;
        reg [5:0] tens;
        reg [5:0] ones;
        begin
            tens = v / 6'h0A;
            ones = v % 6'h0A;
            to_bcd = {tens[3:0], ones[3:0]};
        end
    endfunction

    // Reference generation state.
    reg ext_prev;
    reg [17:0] ext_cnt;
    reg [17:0] ext_period;
    reg [17:0] acc;
    reg ref_tick;
    wire [17:0] step;
    wire [17:0] modulus;
    wire [18:0] acc_sum;
    wire [18:0] acc_rem;
    wire ext_rise;

    // Divider state.
    reg t512;
    reg [7:0] cnt_6k4;
    reg t6k4;
    reg [15:0] cnt_50ms;
    reg rti;
    reg [4:0] cnt_sec;
    reg pps;
    reg [3:0] cnt_half;

    // Time chain state.
    reg half;
    reg [5:0] sec;
    reg [5:0] min;
    reg [4:0] hour;
    reg [4:0] day;
    reg [5:0] trap;
    reg running;

    assign ext_rise = I_EXT_1KHZ & ~ext_prev;
    assign step = I_INTEGRATED ? `EXT_STEP : `XTAL_STEP;
    assign modulus = I_INTEGRATED ? ext_period : `XTAL_MOD;
    // One spare bit keeps a long measured period from wrapping the sum and losing a tick.
    assign acc_sum = {1'b0, acc} + {1'b0, step};
    assign acc_rem = acc_sum - {1'b0, modulus};

    // Measure the external period; a glitch edge keeps the last good period.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            ext_prev <= 1'b0;
            ext_cnt <= 18'h00000;
            ext_period <= `EXT_PERIOD_NOM;
        end else begin
            ext_prev <= I_EXT_1KHZ;
            if (ext_rise) begin
                ext_cnt <= 18'h00001;
                if (ext_cnt >= `EXT_PERIOD_MIN) begin
                    ext_period <= ext_cnt;
                end
            end else if (ext_cnt != `PERIOD_MAX) begin
                ext_cnt <= ext_cnt + 18'h00001;
            end
        end
    end

    // Fractional accumulator: step/modulus of the cycles carry a reference tick.
    // Jitter is one system cycle (8 ns), traded for having no real PLL.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            acc <= 18'h00000;
            ref_tick <= 1'b0;
        end else if (I_INTEGRATED && ext_rise) begin
            acc <= 18'h00000; // Phase follows the external edge.
            ref_tick <= 1'b1;
        end else if (acc_sum >= {1'b0, modulus}) begin
            acc <= acc_rem[17:0]; // Remainder is below the step, so it fits.
            ref_tick <= 1'b1;
        end else begin
            acc <= acc_sum[17:0];
            ref_tick <= 1'b0;
        end
    end

    // Dividers off the 1024 kHz reference tick.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            t512 <= 1'b0;
            cnt_6k4 <= 8'h00;
            t6k4 <= 1'b0;
            cnt_50ms <= 16'h0000;
            rti <= 1'b0;
        end else begin
            rti <= 1'b0;
            if (ref_tick) begin
                t512 <= ~t512; // Divide by 2.
                if (cnt_6k4 == `DIV_6K4 - 8'h01) begin
                    cnt_6k4 <= 8'h00; // Divide by 160.
                end else begin
                    cnt_6k4 <= cnt_6k4 + 8'h01;
                end
                if (cnt_6k4 == `DIV_6K4_HALF - 8'h01 || cnt_6k4 == `DIV_6K4 - 8'h01) begin
                    t6k4 <= ~t6k4;
                end
                if (cnt_50ms == `DIV_50MS - 16'h0001) begin
                    cnt_50ms <= 16'h0000;
                    rti <= 1'b1; // Divide by 51200.
                end else begin
                    cnt_50ms <= cnt_50ms + 16'h0001;
                end
            end
        end
    end

    // Seconds pulse and half-second step from the 50 ms interrupt.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            cnt_sec <= 5'h00;
            cnt_half <= 4'h0;
            pps <= 1'b0;
        end else begin
            pps <= 1'b0;
            if (rti) begin
                if (cnt_sec == `RTI_PER_SEC - 5'h01) begin
                    cnt_sec <= 5'h00;
                    pps <= 1'b1;
                end else begin
                    cnt_sec <= cnt_sec + 5'h01;
                end
                if (cnt_half == `RTI_PER_HALF_SEC - 4'h1) begin
                    cnt_half <= 4'h0;
                end else begin
                    cnt_half <= cnt_half + 4'h1;
                end
            end
        end
    end

    // Minute trap: free-running count of seconds pulses, marks each whole minute.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            trap <= 6'h00;
        end else if (pps) begin
            trap <= (trap == `SEC_WRAP) ? 6'h00 : trap + 6'h01;
        end
    end

    // Time chain with preset and hold until the next whole minute.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            half <= 1'b0;
            sec <= 6'h00;
            min <= 6'h00;
            hour <= 5'h00;
            day <= `DAY_FIRST;
            running <= 1'b1;
        end else if (I_PRESET_LOAD) begin
            half <= 1'b0;
            sec <= 6'h00;
            min <= I_PRESET_MIN;
            hour <= I_PRESET_HOUR;
            day <= I_PRESET_DAY;
            running <= 1'b0;
        end else if (!running) begin
            if (pps && trap == `SEC_WRAP) begin
                running <= 1'b1;
            end
        end else if (rti && cnt_half == `RTI_PER_HALF_SEC - 4'h1) begin
            // Carry ripples only while every lower stage wraps.
            half <= ~half;
            if (half == `HALF_WRAP) begin
                sec <= (sec == `SEC_WRAP) ? 6'h00 : sec + 6'h01;
                if (sec == `SEC_WRAP) begin
                    min <= (min == `MIN_WRAP) ? 6'h00 : min + 6'h01;
                    if (min == `MIN_WRAP) begin
                        hour <= (hour == `HOUR_WRAP) ? 5'h00 : hour + 5'h01;
                        if (hour == `HOUR_WRAP) begin
                            day <= (day >= `DAY_LAST) ? `DAY_FIRST : day + 5'h01;
                        end
                    end
                end
            end
        end
    end

    // Registered, failure-gated outputs and time words.
    always @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_CLK_512K <= 1'b0;
            O_CLK_6K4 <= 1'b0;
            O_PPS <= 1'b0;
            O_RTI <= 1'b0;
            O_TIME_BIN <= {`BIN_WIDTH{1'b0}};
            O_TIME_BCD <= {`BCD_WIDTH{1'b0}};
            O_RUNNING <= 1'b0;
        end else begin
            O_CLK_512K <= t512 & ~I_FAIL_512K;
            O_CLK_6K4 <= t6k4 & ~I_FAIL_6K4;
            O_PPS <= pps & ~I_FAIL_PPS;
            O_RTI <= rti & ~I_FAIL_RTI;
            O_TIME_BIN <= {day, hour, min, sec, half};
            O_TIME_BCD <= {to_bcd({1'b0, day}), to_bcd({1'b0, hour}), to_bcd(min),
                           to_bcd(sec), half};
            O_RUNNING <= running;
        end
    end

endmodule // central_timing_unit

// ---- tb/central_timing_unit_props.sv ----
`timescale 1ns/1ns
module central_timing_unit_props (
    // Clock, reset and controls.
    input wire I_REF_CLK,
    input wire I_RST_N,
    input wire I_FAIL_512K,
    input wire I_FAIL_6K4,
    input wire I_FAIL_PPS,
    input wire I_FAIL_RTI,
    input wire I_PRESET_LOAD,
    input wire [4:0] I_PRESET_DAY,
    input wire [4:0] I_PRESET_HOUR,
    input wire [5:0] I_PRESET_MIN,
    // Watched outputs.
    input wire O_CLK_512K,
    input wire O_CLK_6K4,
    input wire O_PPS,
    input wire O_RTI,
    input wire [22:0] O_TIME_BIN,
    input wire O_RUNNING
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // A load stops the chain two edges on and shows the minute with seconds cleared.
    sequence s_load;
        I_PRESET_LOAD ##2 !O_RUNNING;
    endsequence
    sequence s_shown;
        O_TIME_BIN == {$past(I_PRESET_DAY, 2), $past(I_PRESET_HOUR, 2),
            $past(I_PRESET_MIN, 2), 7'h00};
    endsequence
    a_preset_word: assert property (s_load |-> s_shown)
        else $error("Preset word not shown");
    a_start_whole: assert property ($rose(O_RUNNING) |-> O_TIME_BIN[6:0] == 7'h00)
        else $error("Chain started off a whole minute");
    a_fail_512k: assert property (I_FAIL_512K |=> !O_CLK_512K)
        else $error("Bit clock not suppressed");
    a_fail_6k4: assert property (I_FAIL_6K4 |=> !O_CLK_6K4)
        else $error("Inverter clock not suppressed");
    a_fail_pps: assert property (I_FAIL_PPS |=> !O_PPS)
        else $error("Seconds pulse not suppressed");
    a_fail_rti: assert property (I_FAIL_RTI |=> !O_RTI)
        else $error("Interrupt not suppressed");
    a_rti_single: assert property (O_RTI |=> !O_RTI)
        else $error("Interrupt longer than one cycle");
    a_pps_single: assert property (O_PPS |=> !O_PPS)
        else $error("Seconds pulse longer than one cycle");
endmodule // central_timing_unit_props

bind central_timing_unit central_timing_unit_props chk (.*);

// ---- tb/ext_ref_source.sv ----
`timescale 1ns/1ns
module ext_ref_source #(parameter HALF = 512) (
    // Clock and enable.
    input wire i_clk,
    input wire i_run,
    // Reference square wave.
    output reg o_ref
);
    integer cnt = 0;
    initial o_ref = 1'b0;
    // Scaled reference; held low when stopped, since a quiet line carries no edges.
    always @(posedge i_clk) begin
        cnt <= (!i_run || cnt == HALF - 1) ? 0 : cnt + 1;
        o_ref <= i_run && (o_ref ^ (cnt == HALF - 1));
    end
endmodule // ext_ref_source

// ---- tb/test_central_timing_unit.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module test_central_timing_unit;
    reg clk = 0, rst_n = 0, integ = 0, load = 0, run_ref = 0, p512 = 0, p6k4 = 0, prun = 0;
    reg [3:0] fail = 0;
    reg [4:0] day = 0, hour = 0;
    reg [5:0] mins = 0;
    reg [31:0] lfsr = 32'h71682A0F;
    wire ext, c512, c6k4, pps, rti, running;
    wire [22:0] tbin;
    wire [32:0] tbcd;
    integer n_mismatch = 0, cmp_count = 0, n512 = 0, i;
    reg [55:0] q_word[$];
    integer q_per[$];
    always #4 clk = ~clk;
    ext_ref_source #(.HALF(512)) ref_src (.i_clk(clk), .i_run(run_ref), .o_ref(ext));
    central_timing_unit dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_INTEGRATED(integ),
        .I_EXT_1KHZ(ext), .I_FAIL_512K(fail[0]), .I_FAIL_6K4(fail[1]), .I_FAIL_PPS(fail[2]),
        .I_FAIL_RTI(fail[3]), .I_PRESET_LOAD(load), .I_PRESET_DAY(day), .I_PRESET_HOUR(hour),
        .I_PRESET_MIN(mins), .O_CLK_512K(c512), .O_CLK_6K4(c6k4), .O_PPS(pps), .O_RTI(rti),
        .O_TIME_BIN(tbin), .O_TIME_BCD(tbcd), .O_RUNNING(running));
    function [5:0] rnd(input integer m);
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        rnd = lfsr % m;
    endfunction
    function [7:0] bcd(input [5:0] v);
        bcd = ((v / 10) << 4) | (v % 10);
    endfunction
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task conclude;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bit-clock rises are counted per inverter-clock period, which holds at any tick rate.
    always @(posedge clk) begin
        p512 <= c512;
        p6k4 <= c6k4;
        prun <= running;
        if (c512 && !p512) n512 <= n512 + 1;
        if (c6k4 && !p6k4) begin
            if (q_per.size() > 0) `CHK(n512, q_per.pop_front())
            n512 <= c512 && !p512;
        end
        if (prun && !running && q_word.size() > 0) `CHK({tbin, tbcd}, q_word.pop_front())
    end
    // Cuts a hung run short; a clean run needs about 62500 cycles.
    initial begin
        #(95000 * 8);
        n_mismatch++;
        conclude;
    end
    initial begin
        tick(3);
        rst_n = 1;
        tick(2);
        `CHK({tbin, tbcd, running}, {23'h040000, 33'h002000000, 1'b1})
        for (i = 0; i < 3; i++) begin
            day = 5'(rnd(31) + 1);
            hour = 5'(rnd(24));
            mins = rnd(60);
            q_word.push_back({day, hour, mins, 7'h00, bcd(day), bcd(hour), bcd(mins), 9'h000});
            load = 1;
            tick(2);
            load = 0;
            tick(3);
            `CHK(running, 1'b0)
            rst_n = 0;
            tick(1);
            rst_n = 1;
            tick(2);
        end
        integ = 1;
        run_ref = 1;
        tick(3000);
        @(posedge c6k4);
        tick(1);
        repeat (4) q_per.push_back(80);
        tick(800);
        // Failure gates run long before the crystal check, so no counted period holds a
        // suppressed bit-clock edge or a false inverter-clock edge.
        repeat (300) begin
            fail = 4'(rnd(16));
            tick(1);
        end
        fail = 0;
        i = 0;
        while (rti !== 1'b1 && i < 60000) begin
            tick(1);
            i++;
        end
        `CHK(rti, 1'b1)
        integ = 0;
        run_ref = 0;
        @(posedge c6k4);
        tick(1);
        q_per.push_back(80);
        tick(2);
        `CHK(q_per.size(), 0)
        conclude;
    end
endmodule // test_central_timing_unit
